// >>> pwt_timer.sv
// Six channel capture, compare and PWM timer with an APB register slave.
//
// Design decisions made here: the placing of the registers and the APB register port.

// Contract
// - 16-bit counter behind 1..128 power-two prescaler
// - System clock everywhere; external clock edges sampled
// - Up mode counts zero to terminal, restarts
// - Center mode counts up then down, repeating
// - Up mode overflow flag on terminal-to-zero wrap
// - Center mode overflow flag leaving modulus downward
// - Any counter register write clears counter immediately
// - Counter runs continuously until source set zero
// - Zero modulus means free run to maximum
// - Center mode forces enabled channels to center PWM
// - Capture copies counter on selected pin edge
// - Capture pin passes two-stage synchroniser first
// - Capture mode ignores channel value writes
// - Capture edge sets flag, interrupt when enabled
// - Compare match sets, clears or toggles pin
// - Toggle keeps previous level until next match
// - Compare mode flags every counter value match; the code sets no flag while edge_level_select is ELS_OFF
// - Edge PWM: period modulus plus one, width value
// - Edge PWM polarity: overflow versus match levels
// - Edge PWM: zero gives 0%, above modulus 100%
// - Center PWM: double period and width, limits
// - Center PWM: up match low, down match high
// - Value writes while running load at modulus step
// - Capture edge select: rise, fall, both, off
module pwt_timer
  import pwt_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_clk,
  input wire logic [NUM_CH-1:0] ch_in,
  output logic [NUM_CH-1:0] ch_out,
  output logic [NUM_CH-1:0] ch_oe,
  output logic ovf_irq,
  output logic [NUM_CH-1:0] ch_irq
);

  // Prescaler terminal count for a divide by two to the power sel.
  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    div_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction

  // Channel index of a channel register offset.
  function automatic int ch_of(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - OFF_CH_SC;
    ch_of = int'(rel[7:3]);
  endfunction

  pwt_state_t st_ff;
  pwt_state_t nxt_st;

  logic tick;
  logic cnt_clr;
  logic wr;
  logic [15:0] top;
  logic [15:0] ncnt;
  logic ndown;
  logic load;
  logic [NUM_CH-1:0] cap_evt;

  // All next-state logic: bus slave, prescaler, counter and channels.
  always_comb begin
    logic acc;
    logic hit;
    logic is_ch;
    logic is_sc;
    logic src;
    logic act;
    logic cap_mode;
    logic rise;
    logic fall;
    logic [31:0] rd;
    int ci;
    acc = 1'b0;
    hit = 1'b0;
    is_ch = 1'b0;
    is_sc = 1'b0;
    src = 1'b0;
    act = 1'b0;
    cap_mode = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    rd = 32'h0000_0000;
    ci = 0;
    nxt_st = st_ff;
    cap_evt = '0;

    // Bus decode; every aligned offset up to 0x38, the last channel's value register, is mapped, so 0x3C is not.
    acc = psel && penable;
    hit = (paddr[1:0] == 2'b00) && (paddr <= OFF_LAST);
    is_ch = paddr >= OFF_CH_SC;
    is_sc = is_ch && (((paddr - OFF_CH_SC) & (CH_STRIDE >> 1)) == 8'h00);
    ci = is_ch ? ch_of(paddr) : 0;
    wr = acc && st_ff.pready && pwrite && hit;

    // Read mux; reserved bits and the unused top bits read as zero.
    if (!is_ch) begin
      case (paddr)
        OFF_SC: rd = {24'h0000_00, st_ff.counter_overflow_flag,
          st_ff.overflow_irq_enable, st_ff.center_align_select,
          st_ff.count_clock_source, st_ff.prescale_sel};
        OFF_CNT: rd = {16'h0000, st_ff.cnt};
        OFF_MOD: rd = {16'h0000, st_ff.modulus};
        default: rd = 32'h0000_0000;
      endcase
    end else if (is_sc) begin
      rd = {24'h0000_00, st_ff.ch[ci].channel_event_flag,
        st_ff.ch[ci].channel_irq_enable, st_ff.ch[ci].channel_mode_select,
        st_ff.ch[ci].edge_level_select, 2'b00};
    end else begin
      rd = {16'h0000, st_ff.ch[ci].channel_value_reg};
    end

    // The answer comes one cycle into the access phase, with data held.
    nxt_st.pready = acc && !st_ff.pready;
    nxt_st.pslverr = acc && !st_ff.pready && !hit;
    if (acc && !st_ff.pready) begin
      nxt_st.prdata = (hit && !pwrite) ? rd : 32'h0000_0000;
    end

    // Any write to the counter or modulus restarts the count.
    cnt_clr = wr && (paddr == OFF_CNT || paddr == OFF_MOD);

    // Register writes; flags only clear on a written zero.
    if (wr && paddr == OFF_SC) begin
      nxt_st.counter_overflow_flag = st_ff.counter_overflow_flag &&
        pwdata[POS_FLAG];
      nxt_st.overflow_irq_enable = pwdata[POS_IE];
      nxt_st.center_align_select = pwdata[POS_CPWMS];
      nxt_st.count_clock_source = pwdata[POS_CLK_SEL +: 2];
      nxt_st.prescale_sel = pwdata[2:0];
    end
    if (wr && paddr == OFF_MOD) begin
      nxt_st.modulus = pwdata[15:0];
    end
    if (wr && is_sc) begin
      nxt_st.ch[ci].channel_event_flag = st_ff.ch[ci].channel_event_flag &&
        pwdata[POS_FLAG];
      nxt_st.ch[ci].channel_irq_enable = pwdata[POS_IE];
      nxt_st.ch[ci].channel_mode_select = pwdata[POS_MS +: 2];
      nxt_st.ch[ci].edge_level_select = pwdata[POS_ELS +: 2];
    end
    // Capture channels own their value register, so writes are dropped.
    if (wr && is_ch && !is_sc && !(!st_ff.center_align_select &&
        st_ff.ch[ci].channel_mode_select == MS_CAPTURE)) begin
      if (st_ff.count_clock_source == CLK_OFF) begin
        nxt_st.ch[ci].channel_value_reg = pwdata[15:0];
        nxt_st.ch[ci].value_pend = 1'b0;
      end else begin
        nxt_st.ch[ci].value_buf = pwdata[15:0];
        nxt_st.ch[ci].value_pend = 1'b1;
      end
    end

    // External clock is synchronised and counted on its rising edge.
    nxt_st.ext_sync = {st_ff.ext_sync[1:0], ext_count_clk};
    if (st_ff.count_clock_source == CLK_EXT) begin
      src = st_ff.ext_sync[1] && !st_ff.ext_sync[2];
    end else begin
      src = st_ff.count_clock_source != CLK_OFF;
    end
    tick = src && (st_ff.pre == div_mask(st_ff.prescale_sel));
    if (src) begin
      nxt_st.pre = tick ? 7'h00 : st_ff.pre + 7'h01;
    end

    // Counter step; a zero modulus runs the full range.
    top = (st_ff.modulus == CNT_ZERO) ? CNT_MAX : st_ff.modulus;
    ncnt = st_ff.cnt;
    ndown = 1'b0;
    if (!st_ff.center_align_select) begin
      ncnt = (st_ff.cnt == top) ? CNT_ZERO : st_ff.cnt + 16'h0001;
    end else if (!st_ff.count_down) begin
      ndown = st_ff.cnt >= top;
      ncnt = ndown ? st_ff.cnt - 16'h0001 : st_ff.cnt + 16'h0001;
    end else begin
      ndown = st_ff.cnt != CNT_ZERO;
      ncnt = ndown ? st_ff.cnt - 16'h0001 : st_ff.cnt + 16'h0001;
    end
    load = tick && !cnt_clr && !st_ff.count_down &&
      st_ff.cnt == top - 16'h0001;

    if (cnt_clr) begin
      nxt_st.cnt = CNT_ZERO;
      nxt_st.count_down = 1'b0;
      nxt_st.pre = 7'h00;
    end else if (tick) begin
      nxt_st.cnt = ncnt;
      nxt_st.count_down = ndown;
      // Overflow marks wrap in up mode and the turn in center mode.
      if (!st_ff.center_align_select && st_ff.cnt == top) begin
        nxt_st.counter_overflow_flag = 1'b1;
      end
      if (st_ff.center_align_select && ndown && !st_ff.count_down) begin
        nxt_st.counter_overflow_flag = 1'b1;
      end
    end

    // Channels.
    for (int i = 0; i < NUM_CH; i++) begin
      nxt_st.ch[i].pin_sync = {st_ff.ch[i].pin_sync[1:0], ch_in[i]};
      cap_mode = !st_ff.center_align_select &&
        st_ff.ch[i].channel_mode_select == MS_CAPTURE;
      act = !st_ff.ch[i].edge_level_select[0];
      nxt_st.ch[i].pin_oe = !cap_mode &&
        st_ff.ch[i].edge_level_select != ELS_OFF;

      // Buffered values land on the step into the terminal count.
      if (st_ff.ch[i].value_pend &&
          (load || st_ff.count_clock_source == CLK_OFF)) begin
        nxt_st.ch[i].channel_value_reg = st_ff.ch[i].value_buf;
        nxt_st.ch[i].value_pend = 1'b0;
      end

      // Edges are taken between the second and third stages only.
      rise = st_ff.ch[i].pin_sync[1] && !st_ff.ch[i].pin_sync[2];
      fall = !st_ff.ch[i].pin_sync[1] && st_ff.ch[i].pin_sync[2];
      if (cap_mode) begin
        case (st_ff.ch[i].edge_level_select)
          ELS_RISE: cap_evt[i] = rise;
          ELS_FALL: cap_evt[i] = fall;
          ELS_BOTH: cap_evt[i] = rise || fall;
          default: cap_evt[i] = 1'b0;
        endcase
        if (cap_evt[i]) begin
          nxt_st.ch[i].channel_value_reg = st_ff.cnt;
          nxt_st.ch[i].channel_event_flag = 1'b1;
        end
      end else if (tick && !cnt_clr &&
          st_ff.ch[i].edge_level_select != ELS_OFF) begin
        if (st_ff.center_align_select) begin
          // Center PWM; the limits never match so no flag is set.
          if (st_ff.ch[i].channel_value_reg == CNT_ZERO) begin
            nxt_st.ch[i].pin_out = !act;
          end else if (st_ff.ch[i].channel_value_reg > top) begin
            nxt_st.ch[i].pin_out = act;
          end else if (ncnt == st_ff.ch[i].channel_value_reg) begin
            nxt_st.ch[i].pin_out = ndown ? act : !act;
            nxt_st.ch[i].channel_event_flag = 1'b1;
          end
        end else if (st_ff.ch[i].channel_mode_select == MS_COMPARE) begin
          if (ncnt == st_ff.ch[i].channel_value_reg) begin
            case (st_ff.ch[i].edge_level_select)
              ELS_RISE: nxt_st.ch[i].pin_out =
                !st_ff.ch[i].pin_out;
              ELS_FALL: nxt_st.ch[i].pin_out = 1'b0;
              default: nxt_st.ch[i].pin_out = 1'b1;
            endcase
            nxt_st.ch[i].channel_event_flag = 1'b1;
          end
        end else begin
          // Edge PWM: active from the wrap, inactive from the match.
          if (st_ff.ch[i].channel_value_reg == CNT_ZERO) begin
            nxt_st.ch[i].pin_out = !act;
          end else if (st_ff.ch[i].channel_value_reg > top) begin
            nxt_st.ch[i].pin_out = act;
          end else if (ncnt == st_ff.ch[i].channel_value_reg) begin
            nxt_st.ch[i].pin_out = !act;
            nxt_st.ch[i].channel_event_flag = 1'b1;
          end else if (ncnt == CNT_ZERO) begin
            nxt_st.ch[i].pin_out = act;
          end
        end
      end
      nxt_st.ch_irq[i] = st_ff.ch[i].channel_event_flag &&
        st_ff.ch[i].channel_irq_enable;
    end
    nxt_st.ovf_irq = st_ff.counter_overflow_flag && st_ff.overflow_irq_enable;
  end

  // State register; the clock enable freezes everything while low.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.modulus <= MOD_RESET;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs are taken straight from the state register.
  always_comb begin
    prdata = st_ff.prdata;
    pready = st_ff.pready;
    pslverr = st_ff.pslverr;
    ovf_irq = st_ff.ovf_irq;
    ch_irq = st_ff.ch_irq;
    for (int i = 0; i < NUM_CH; i++) begin
      ch_out[i] = st_ff.ch[i].pin_out;
      ch_oe[i] = st_ff.ch[i].pin_oe;
    end
  end

  a_up_wrap: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && tick && !cnt_clr && !st_ff.center_align_select &&
    st_ff.cnt == top |=> st_ff.cnt == CNT_ZERO &&
    st_ff.counter_overflow_flag)
    else $error("Up count did not wrap with overflow.");

  a_center_turn: assert property (@(posedge clock)
    disable iff (!nrst)
    clk_en && tick && !cnt_clr && st_ff.center_align_select &&
    !st_ff.count_down && st_ff.cnt == top |=> st_ff.count_down &&
    st_ff.cnt == $past(st_ff.cnt) - 16'h0001 &&
    st_ff.counter_overflow_flag)
    else $error("Center count did not turn with overflow.");

  a_cnt_clear: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && cnt_clr |=> st_ff.cnt == CNT_ZERO)
    else $error("Counter write did not clear the count.");

  a_stop_hold: assert property (@(posedge clock) disable iff (!nrst)
    st_ff.count_clock_source == CLK_OFF && !cnt_clr
    |=> st_ff.cnt == $past(st_ff.cnt))
    else $error("Stopped counter moved.");

  // Channel one is the capture channel that the scenarios exercise.
  a_capture_take: assert property (@(posedge clock)
    disable iff (!nrst)
    clk_en && cap_evt[1] |=> st_ff.ch[1].channel_value_reg ==
    $past(st_ff.cnt) && st_ff.ch[1].channel_event_flag ##1
    ch_irq[1] == st_ff.ch[1].channel_irq_enable)
    else $error("Capture did not store count and flag.");

  a_capture_ro: assert property (@(posedge clock)
    disable iff (!nrst)
    clk_en && wr && paddr == OFF_CH_V + CH_STRIDE && !cap_evt[1] &&
    !st_ff.center_align_select &&
    st_ff.ch[1].channel_mode_select == MS_CAPTURE
    |=> $stable(st_ff.ch[1].channel_value_reg))
    else $error("Capture value changed by a write.");

  // Channel two is the compare channel that the scenarios exercise.
  a_toggle_match: assert property (@(posedge clock)
    disable iff (!nrst)
    clk_en && tick && !cnt_clr && !st_ff.center_align_select &&
    st_ff.ch[2].channel_mode_select == MS_COMPARE &&
    st_ff.ch[2].edge_level_select == ELS_RISE &&
    ncnt == st_ff.ch[2].channel_value_reg
    |=> ch_out[2] != $past(ch_out[2]))
    else $error("Toggle compare did not invert the pin.");

  a_edge_zero: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && tick && !cnt_clr && !st_ff.center_align_select &&
    st_ff.ch[0].channel_mode_select[1] &&
    st_ff.ch[0].edge_level_select == ELS_FALL &&
    st_ff.ch[0].channel_value_reg == CNT_ZERO |=> !ch_out[0])
    else $error("Zero duty edge PWM drove high.");

  a_tof_hold: assert property (@(posedge clock) disable iff (!nrst)
    st_ff.counter_overflow_flag && !(wr && paddr == OFF_SC &&
    !pwdata[POS_FLAG]) |=> st_ff.counter_overflow_flag)
    else $error("Overflow flag dropped without a zero write.");

endmodule

// >>> pwt_pkg.sv
// Constants, field layouts and state types for the six channel timer.
package pwt_pkg;

  localparam int NUM_CH = 6;

  // Register byte offsets; channel registers repeat every eight bytes.
  localparam logic [7:0] OFF_SC = 8'h00;
  localparam logic [7:0] OFF_CNT = 8'h04;
  localparam logic [7:0] OFF_MOD = 8'h08;
  localparam logic [7:0] OFF_CH_SC = 8'h0C;
  localparam logic [7:0] OFF_CH_V = 8'h10;
  localparam logic [7:0] CH_STRIDE = 8'h08;
  localparam logic [7:0] OFF_LAST = 8'h38;

  // Field positions shared by the control registers.
  localparam int POS_FLAG = 7;
  localparam int POS_IE = 6;
  localparam int POS_CPWMS = 5;
  localparam int POS_CLK_SEL = 3;
  localparam int POS_MS = 4;
  localparam int POS_ELS = 2;

  // Values after reset and count limits.
  localparam logic [15:0] MOD_RESET = 16'hFFFF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [1:0] CLK_OFF = 2'h0;
  localparam logic [1:0] CLK_EXT = 2'h3;

  // Channel mode and edge or action codes.
  localparam logic [1:0] MS_CAPTURE = 2'h0;
  localparam logic [1:0] MS_COMPARE = 2'h1;
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_RISE = 2'h1;
  localparam logic [1:0] ELS_FALL = 2'h2;
  localparam logic [1:0] ELS_BOTH = 2'h3;

  typedef struct packed {
    logic channel_event_flag;
    logic channel_irq_enable;
    logic [1:0] channel_mode_select;
    logic [1:0] edge_level_select;
    logic [15:0] channel_value_reg;
    logic [15:0] value_buf;
    logic value_pend;
    logic [2:0] pin_sync;
    logic pin_out;
    logic pin_oe;
  } pwt_ch_t;

  typedef struct packed {
    logic counter_overflow_flag;
    logic overflow_irq_enable;
    logic center_align_select;
    logic [1:0] count_clock_source;
    logic [2:0] prescale_sel;
    logic [15:0] cnt;
    logic [15:0] modulus;
    logic count_down;
    logic [6:0] pre;
    logic [2:0] ext_sync;
    pwt_ch_t [NUM_CH-1:0] ch;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic ovf_irq;
    logic [NUM_CH-1:0] ch_irq;
  } pwt_state_t;

endpackage

// >>> pwt_pins_model.sv
// Far-side model of the six channel pins and the external count clock.
module pwt_pins_model
  import pwt_pkg::*;
(
  input wire logic clock,
  input wire logic [NUM_CH-1:0] ch_out,
  input wire logic [NUM_CH-1:0] ch_oe,
  output logic [NUM_CH-1:0] ch_in,
  output logic ext_count_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [NUM_CH-1:0] drv_ff = '0;
  logic ext_ff = 1'b0;

  // A pin the block drives reads back its own level; the others see our source.
  assign ch_in = (ch_oe & ch_out) | (~ch_oe & drv_ff);
  assign ext_count_clk = ext_ff;

  // Source edges land just after a system clock edge, never on it.
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge clock);
    drv_ff[idx] <= lvl;
  endtask

  // Each pulse holds three system clocks high and four low, so the sampler
  // cannot miss it; the line rests low between bursts instead of running free.
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clock);
      ext_ff <= 1'b1;
      repeat (3) @(posedge clock);
      ext_ff <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
endmodule

// >>> tb.sv
// Self-checking bench for the six channel timer over APB and its pins.
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  n_fail++; $display("unexpected %s exp %h got %h", nm, ex, got); end end

module tb
  import pwt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_count_clk;
  logic [NUM_CH-1:0] ch_in;
  logic [NUM_CH-1:0] ch_out;
  logic [NUM_CH-1:0] ch_oe;
  logic ovf_irq;
  logic [NUM_CH-1:0] ch_irq;
  int n_fail = 0;
  int compares = 0;
  int hi;
  int per;
  logic [31:0] rdat;
  logic rerr;
  logic [15:0] cap;

  // Free-running 100 MHz system clock.
  always #5 clock = ~clock;

  pwt_timer dut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_clk(ext_count_clk), .ch_in(ch_in), .ch_out(ch_out),
    .ch_oe(ch_oe), .ovf_irq(ovf_irq), .ch_irq(ch_irq));

  pwt_pins_model pins (.clock(clock), .ch_out(ch_out), .ch_oe(ch_oe),
    .ch_in(ch_in), .ext_count_clk(ext_count_clk));

  function automatic logic [7:0] csc(input int i);
    return OFF_CH_SC + CH_STRIDE * 8'(i);
  endfunction

  function automatic logic [7:0] cv(input int i);
    return OFF_CH_V + CH_STRIDE * 8'(i);
  endfunction

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // High time and full period of a pin, from one rising edge to the next.
  task automatic measure(input int i);
    int n;
    n = 0;
    hi = 0;
    while (ch_out[i] === 1'b1 && n++ < 3000) @(posedge clock);
    while (ch_out[i] !== 1'b1 && n++ < 3000) @(posedge clock);
    while (ch_out[i] === 1'b1 && hi < 3000) begin
      @(posedge clock);
      hi++;
    end
    per = hi;
    while (ch_out[i] !== 1'b1 && per < 6000) begin
      @(posedge clock);
      per++;
    end
  endtask

  // Counts cycles off the expected level once the pin has had time to settle.
  task automatic steady(input int i, input logic lvl);
    hi = 0;
    repeat (8) @(posedge clock);
    repeat (20) begin
      @(posedge clock);
      if (ch_out[i] !== lvl) hi++;
    end
  endtask

  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // The tests need some three thousand cycles; twenty thousand means a hang.
  initial begin
    #200_000;
    n_fail++;
    test_done;
  end

  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    rd(OFF_SC);
    `CHK("sc reset", 32'h0, rdat);
    rd(OFF_MOD);
    `CHK("mod reset", 32'h0000_ffff, rdat);
    for (int i = 0; i < NUM_CH; i++) begin
      rd(csc(i));
      `CHK("ch ctrl reset", 32'h0, rdat);
      rd(cv(i));
      `CHK("ch value reset", 32'h0, rdat);
    end
    rd(8'h3C);
    `CHK("unmapped error", 1'b1, rerr);
    $display("test registers over");
    // Edge PWM at every prescaler setting; configured while stopped.
    wr(OFF_MOD, 32'h3);
    wr(csc(0), 32'h28);
    wr(cv(0), 32'h2);
    for (int d = 0; d < 8; d++) begin
      wr(OFF_SC, 32'h0);
      wr(OFF_CNT, 32'h0);
      wr(OFF_SC, 32'h8 | 32'(d));
      measure(0);
      `CHK("pwm high", 2 << d, hi);
      `CHK("pwm period", 4 << d, per);
    end
    wr(OFF_SC, 32'h0);
    wr(csc(0), 32'h24);
    wr(cv(0), 32'h1);
    wr(OFF_SC, 32'h8);
    measure(0);
    `CHK("low-true high", 3, hi);
    wr(OFF_SC, 32'h0);
    wr(csc(0), 32'h28);
    wr(cv(0), 32'h0);
    wr(OFF_SC, 32'h8);
    steady(0, 1'b0);
    `CHK("zero duty", 0, hi);
    wr(OFF_SC, 32'h0);
    wr(cv(0), 32'h5);
    wr(OFF_SC, 32'h8);
    steady(0, 1'b1);
    `CHK("full duty", 0, hi);
    $display("test edge pwm over");
    // Overflow flag: a write of one keeps it, only a zero clears it.
    wr(OFF_SC, 32'h48);
    repeat (10) @(posedge clock);
    `CHK("ovf irq", 1'b1, ovf_irq);
    wr(OFF_SC, 32'h80);
    rd(OFF_SC);
    `CHK("ovf kept", 1'b1, rdat[7]);
    wr(OFF_SC, 32'h0);
    rd(OFF_SC);
    `CHK("ovf cleared", 1'b0, rdat[7]);
    $display("test overflow over");
    // Compare actions: set, clear, then toggle from the held level.
    wr(csc(2), 32'h1C);
    wr(cv(2), 32'h1);
    wr(OFF_SC, 32'h8);
    steady(2, 1'b1);
    `CHK("cmp set", 0, hi);
    wr(csc(2), 32'h18);
    steady(2, 1'b0);
    `CHK("cmp clear", 0, hi);
    wr(csc(2), 32'h14);
    `CHK("toggle holds", 1'b0, ch_out[2]);
    measure(2);
    `CHK("toggle period", 8, per);
    rd(csc(2));
    `CHK("cmp flag", 1'b1, rdat[7]);
    $display("test compare over");
    // Center mode forces a capture-mode channel into center PWM.
    // Center mode goes on first, stopped, or the value write is dropped.
    wr(OFF_SC, 32'h20);
    wr(OFF_MOD, 32'h4);
    wr(csc(3), 32'h08);
    wr(cv(3), 32'h2);
    wr(OFF_SC, 32'h28);
    measure(3);
    `CHK("center high", 4, hi);
    `CHK("center period", 8, per);
    `CHK("center oe", 1'b1, ch_oe[3]);
    rd(csc(3));
    `CHK("center flag", 1'b1, rdat[7]);
    rd(OFF_SC);
    `CHK("center ovf", 1'b1, rdat[7]);
    $display("test center over");
    // Capture against a stopped counter so the copied value is known.
    wr(OFF_SC, 32'h0);
    wr(OFF_MOD, 32'h0);
    wr(OFF_SC, 32'h8);
    repeat (37) @(posedge clock);
    // A running write waits for the step to the top; stopping loads it.
    wr(cv(0), 32'h7);
    rd(cv(0));
    `CHK("value buffered", 32'h5, rdat);
    wr(OFF_SC, 32'h0);
    rd(cv(0));
    `CHK("value loaded", 32'h7, rdat);
    rd(OFF_CNT);
    cap = rdat[15:0];
    rd(OFF_CNT);
    `CHK("cnt stopped", cap, rdat[15:0]);
    `CHK("free run", 1'b1, cap > 16'd20);
    for (int e = 0; e < 4; e++) begin
      wr(csc(1), 32'h40 | 32'(e << 2));
      pins.set_pin(1, 1'b1);
      repeat (8) @(posedge clock);
      rd(csc(1));
      `CHK("rise flag", e[0], rdat[7]);
      `CHK("capture irq", e[0], ch_irq[1]);
      wr(csc(1), 32'h40 | 32'(e << 2));
      pins.set_pin(1, 1'b0);
      repeat (8) @(posedge clock);
      rd(csc(1));
      `CHK("fall flag", e[1], rdat[7]);
    end
    rd(cv(1));
    `CHK("captured", {16'h0, cap}, rdat);
    wr(cv(1), 32'h1234);
    rd(cv(1));
    `CHK("capture ro", {16'h0, cap}, rdat);
    $display("test capture over");
    // External source: five sampled edges against a modulus of three.
    wr(OFF_MOD, 32'h3);
    wr(OFF_SC, 32'h18);
    pins.ext_pulses(5);
    repeat (8) @(posedge clock);
    wr(OFF_SC, 32'h0);
    rd(OFF_CNT);
    `CHK("ext count", 32'h1, rdat);
    wr(OFF_CNT, 32'hffff);
    rd(OFF_CNT);
    `CHK("cnt write", 32'h0, rdat);
    $display("test external over");
    test_done;
  end
endmodule
